// ---- rtl/ebu_pkg.sv ----
package ebu_pkg;
  // Bus configuration word fields
  localparam int BC_WAIT_LSB = 0;
  localparam int BC_WAIT_W = 4;
  localparam int BC_TRI = 4;
  localparam int BC_ALE = 5;
  localparam int BC_RWD = 6;
  localparam int BC_MUX = 7;
  localparam int BC_BYTE = 8;
  localparam int BC_RDYEN = 9;
  localparam int BC_ACT = 10;
  localparam int BC_READY_POLARITY = 11;
  // Window address select fields: base A23..A12, size code
  localparam int WS_SIZE_LSB = 0;
  localparam int WS_BASE_LSB = 4;
  // Address space codes and upper address lanes
  localparam logic [1:0] SPACE_64K = 2'h0;
  localparam logic [1:0] SPACE_256K = 2'h1;
  localparam logic [1:0] SPACE_1M = 2'h2;
  localparam logic [1:0] SPACE_16M = 2'h3;
  localparam logic [7:0] UPPER_64K = 8'h00;
  localparam logic [7:0] UPPER_256K = 8'h03;
  localparam logic [7:0] UPPER_1M = 8'h0f;
  localparam logic [7:0] UPPER_16M = 8'hff;
  // Chip select indices and reset values
  localparam int NUM_WIN = 4;
  localparam logic [2:0] CS_DEFAULT = 3'h4;
  localparam logic [4:0] CS_OFF = 5'h1f;
  localparam logic [15:0] DOE_WORD = 16'hffff;
  localparam logic [15:0] DOE_BYTE = 16'h00ff;
  localparam logic [2:0] SYNC_RESET_HI = 3'h7;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_DELAY = 6'h04,
    ST_STROBE = 6'h08,
    ST_TRI = 6'h10,
    ST_HOLD = 6'h20
  } ebu_state_t;
endpackage

// ---- rtl/ebu_ctrl.sv ----
`timescale 1ns/10ps
module ebu_ctrl
  import ebu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic single_chip,
  input wire logic [1:0] addr_space,
  input wire logic [15:0] default_bus_config,
  input wire logic [NUM_WIN-1:0][15:0] window_bus_config,
  input wire logic [NUM_WIN-1:0][15:0] window_address_select,
  input wire logic chip_select_timing_cfg,
  input wire logic arbitration_enable,
  input wire logic hold_ack_direction,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [23:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic resp_valid,
  output logic resp_err,
  output logic [15:0] resp_rdata,
  input wire logic [15:0] data_port_in,
  output logic [15:0] data_port_out,
  output logic [15:0] data_port_oe,
  output logic [15:0] address_port,
  output logic address_port_oe,
  output logic [7:0] upper_address,
  output logic [7:0] upper_address_oe,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [4:0] chip_select_n,
  output logic bus_pins_oe,
  input wire logic ready_in,
  input wire logic hold_request_n,
  input wire logic hold_ack_n_in,
  output logic hold_ack_n_out,
  output logic hold_ack_n_oe,
  output logic bus_request_n
);

  typedef struct packed {
    ebu_state_t st;
    logic [3:0] cnt;
    logic [15:0] cfg;
    logic [2:0] win;
    logic [23:0] addr;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic resp_valid;
    logic resp_err;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [4:0] cs_n;
    logic [15:0] dout;
    logic [15:0] doe;
    logic [2:0] rdy_s;
    logic rdy;
    logic [2:0] hold_s;
    logic hold_n;
    logic [2:0] ack_s;
    logic ack_n;
    logic bus_request_out_n;
    logic hold_acknowledge_n;
  } ebu_regs_t;
  localparam ebu_regs_t REGS_RESET = '{st: ST_IDLE, cs_n: CS_OFF, rd_n: 1'b1, wr_n: 1'b1,
    hold_s: SYNC_RESET_HI, hold_n: 1'b1, ack_s: SYNC_RESET_HI, ack_n: 1'b1,
    bus_request_out_n: 1'b1, hold_acknowledge_n: 1'b1, default: '0};
  ebu_regs_t r_reg;
  ebu_regs_t r_next;
  logic [4:0] cs_half_reg;
  logic [NUM_WIN-1:0] hit;
  logic [2:0] sel_win;
  logic [15:0] sel_cfg;
  logic arb;
  logic owned;
  logic rdy_active;
  // Window match: base compared above the window size
  function automatic logic win_match(input logic [15:0] sel, input logic [15:0] cfg,
                                     input logic [23:0] a);
    logic [11:0] base;
    logic [3:0] sz;
    base = sel[WS_BASE_LSB +: 12];
    sz = sel[WS_SIZE_LSB +: 4];
    win_match = cfg[BC_ACT] && ((a[23:12] >> sz) == (base >> sz));
  endfunction

  // Upper address lanes per address space
  function automatic logic [7:0] upper_mask(input logic [1:0] sp);
    unique case (sp)
      SPACE_64K: upper_mask = UPPER_64K;
      SPACE_256K: upper_mask = UPPER_256K;
      SPACE_1M: upper_mask = UPPER_1M;
      default: upper_mask = UPPER_16M;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++) begin : g_hit
      assign hit[gi] = win_match(window_address_select[gi], window_bus_config[gi], req_addr);
    end
  endgenerate
  // Fixed priority; four over three over two over one, default last
  always_comb begin
    if (hit[3]) begin
      sel_win = 3'h3;
    end else if (hit[2]) begin
      sel_win = 3'h2;
    end else if (hit[1]) begin
      sel_win = 3'h1;
    end else if (hit[0]) begin
      sel_win = 3'h0;
    end else begin
      sel_win = CS_DEFAULT;
    end
    sel_cfg = (sel_win == CS_DEFAULT) ? default_bus_config : window_bus_config[sel_win[1:0]];
  end

  assign arb = arbitration_enable && !single_chip;
  assign owned = !single_chip && (r_reg.st != ST_HOLD);
  assign rdy_active = (r_reg.rdy == r_reg.cfg[BC_READY_POLARITY]);

  // Take a request in idle while the bus is ours and nobody asks for it, or in single chip mode to answer it with an error
  assign req_ready = (r_reg.st == ST_IDLE) &&
    (single_chip || !arb || (hold_ack_direction ? !r_reg.ack_n : r_reg.hold_n));

  // Bus sequencer and arbitration
  always_comb begin
    r_next = r_reg;
    r_next.resp_valid = 1'b0;
    r_next.resp_err = 1'b0;
    // Pins from outside: three stages, change taken when last two agree
    r_next.rdy_s = {r_reg.rdy_s[1:0], ready_in};
    r_next.hold_s = {r_reg.hold_s[1:0], hold_request_n};
    r_next.ack_s = {r_reg.ack_s[1:0], hold_ack_n_in};
    if (r_reg.rdy_s[1] == r_reg.rdy_s[2]) begin
      r_next.rdy = r_reg.rdy_s[2];
    end
    if (r_reg.hold_s[1] == r_reg.hold_s[2]) begin
      r_next.hold_n = r_reg.hold_s[2];
    end
    if (r_reg.ack_s[1] == r_reg.ack_s[2]) begin
      r_next.ack_n = r_reg.ack_s[2];
    end
    unique case (r_reg.st)
      ST_IDLE: begin
        r_next.bus_request_out_n = 1'b1;
        if (req_valid && req_ready && single_chip) begin
          r_next.resp_valid = 1'b1;
          r_next.resp_err = 1'b1;
        end else if (req_valid && req_ready) begin
          r_next.st = ST_ADDR;
          r_next.cfg = sel_cfg;
          r_next.win = sel_win;
          r_next.addr = req_addr;
          r_next.wr = req_write;
          r_next.wdata = req_wdata;
          r_next.ale = 1'b1;
          r_next.cnt = {3'h0, sel_cfg[BC_ALE]};
          r_next.cs_n = CS_OFF & ~(5'h01 << sel_win);
          if (sel_cfg[BC_MUX]) begin
            r_next.dout = req_addr[15:0];
            r_next.doe = DOE_WORD;
          end else begin
            r_next.doe = '0;
          end
        end else if (arb && !hold_ack_direction && !r_reg.hold_n) begin
          r_next.st = ST_HOLD;
          r_next.hold_acknowledge_n = 1'b0;
        end else if (arb && hold_ack_direction) begin
          r_next.bus_request_out_n = !req_valid;
          if (r_reg.ack_n) begin
            r_next.st = ST_HOLD;
          end
        end
      end
      ST_ADDR: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - CNT_ONE;
        end else begin
          r_next.ale = 1'b0;
          if (r_reg.wr) begin
            r_next.dout = r_reg.cfg[BC_BYTE] ? {8'h00, r_reg.wdata[7:0]} : r_reg.wdata;
            r_next.doe = r_reg.cfg[BC_BYTE] ? DOE_BYTE : DOE_WORD;
          end else begin
            r_next.doe = '0;
          end
          if (r_reg.cfg[BC_RWD]) begin
            r_next.st = ST_DELAY;
          end else begin
            r_next.st = ST_STROBE;
            r_next.rd_n = r_reg.wr;
            r_next.wr_n = !r_reg.wr;
            r_next.cnt = r_reg.cfg[BC_WAIT_LSB +: BC_WAIT_W];
          end
        end
      end
      ST_DELAY: begin
        r_next.st = ST_STROBE;
        r_next.rd_n = r_reg.wr;
        r_next.wr_n = !r_reg.wr;
        r_next.cnt = r_reg.cfg[BC_WAIT_LSB +: BC_WAIT_W];
      end
      ST_STROBE: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - CNT_ONE;
        end else if (!r_reg.cfg[BC_RDYEN] || rdy_active) begin
          r_next.rd_n = 1'b1;
          r_next.wr_n = 1'b1;
          r_next.cs_n = CS_OFF;
          r_next.doe = '0;
          r_next.resp_valid = 1'b1;
          r_next.rdata = r_reg.cfg[BC_BYTE] ? {8'h00, data_port_in[7:0]} : data_port_in;
          r_next.st = r_reg.cfg[BC_TRI] ? ST_TRI : ST_IDLE;
        end
      end
      ST_TRI: begin
        r_next.st = ST_IDLE;
      end
      ST_HOLD: begin
        r_next.cs_n = CS_OFF;
        r_next.bus_request_out_n = !req_valid;
        if (!arb) begin
          r_next.st = ST_IDLE;
          r_next.hold_acknowledge_n = 1'b1;
          r_next.bus_request_out_n = 1'b1;
        end else if (!hold_ack_direction && r_reg.hold_n) begin
          r_next.st = ST_IDLE;
          r_next.hold_acknowledge_n = 1'b1;
        end else if (hold_ack_direction && !r_reg.ack_n) begin
          r_next.st = ST_IDLE;
        end
      end
    endcase
  end

  // All rising-edge state; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= REGS_RESET;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // Half-cycle copy of the selects; the only falling-edge stage in the block
  always_ff @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_half_reg <= CS_OFF;
    end else if (clk_en) begin
      cs_half_reg <= r_reg.cs_n;
    end
  end

  // Pin drive; bus pins float in single chip mode and while held, hold acknowledge driven only as arbitration master, bus request stays driven
  assign chip_select_n = chip_select_timing_cfg ? r_reg.cs_n : cs_half_reg;
  assign bus_pins_oe = owned;
  assign ale = r_reg.ale;
  assign rd_n = r_reg.rd_n;
  assign wr_n = r_reg.wr_n;
  assign data_port_out = r_reg.dout;
  assign data_port_oe = owned ? r_reg.doe : '0;
  assign address_port = r_reg.addr[15:0];
  assign address_port_oe = owned && !r_reg.cfg[BC_MUX] && (r_reg.st != ST_IDLE);
  assign upper_address = r_reg.addr[23:16] & upper_mask(addr_space);
  assign upper_address_oe = owned ? upper_mask(addr_space) : 8'h00;
  assign hold_ack_n_out = r_reg.hold_acknowledge_n;
  assign hold_ack_n_oe = arb && !hold_ack_direction;
  assign bus_request_n = r_reg.bus_request_out_n;
  assign resp_valid = r_reg.resp_valid;
  assign resp_err = r_reg.resp_err;
  assign resp_rdata = r_reg.rdata;
  // Checks kept beside the logic
  sequence ale_rise_long;
    $rose(ale) && r_reg.cfg[BC_ALE];
  endsequence
  sequence ready_wait_open;
    (r_reg.st == ST_STROBE) && (r_reg.cnt == 4'h0) && r_reg.cfg[BC_RDYEN] && !rdy_active;
  endsequence
  single_chip_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    single_chip |-> !ale && !bus_pins_oe && (data_port_oe == '0) && (upper_address_oe == 8'h00))
    else $error("bus pins driven in single chip mode");
  demux_address_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ale && !r_reg.cfg[BC_MUX] && !single_chip) |-> address_port_oe && (data_port_oe == '0))
    else $error("demultiplexed address phase wrong");
  mux_address_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ale && r_reg.cfg[BC_MUX] && owned) |-> (data_port_out == r_reg.addr[15:0]) && (data_port_oe == DOE_WORD))
    else $error("multiplexed address not on shared port");
  ale_length_a: assert property (@(posedge clk) disable iff (!rst_b || !clk_en)
    ale_rise_long |=> ale ##1 !ale)
    else $error("long address strobe not two cycles");
  window_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
    (req_valid && req_ready && !single_chip && clk_en && hit[3] && hit[2]) |=> (r_reg.win == 3'h3)
      && (r_reg.cfg == window_bus_config[3]))
    else $error("window four did not win over three");
  default_window_a: assert property (@(posedge clk) disable iff (!rst_b)
    (req_valid && req_ready && !single_chip && clk_en && (hit == '0)) |=> (r_reg.cs_n == 5'h0f)
      && (r_reg.cfg == $past(default_bus_config)))
    else $error("default window not used");
  ready_hold_a: assert property (@(posedge clk) disable iff (!rst_b || !clk_en)
    ready_wait_open |=> (rd_n == $past(rd_n)) && (wr_n == $past(wr_n)) && !resp_valid)
    else $error("cycle ended without active ready");
  upper_lanes_a: assert property (@(posedge clk) disable iff (!rst_b)
    (owned && (addr_space == SPACE_1M)) |-> (upper_address_oe == 8'h0f) && (upper_address[7:4] == 4'h0))
    else $error("upper address lanes wrong for 1M space");
  cs_half_a: assert property (@(negedge clk) disable iff (!rst_b || !clk_en)
    ($rose(ale) && !chip_select_timing_cfg) |-> (chip_select_n == CS_OFF))
    else $error("chip select moved before half cycle");
  cs_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(ale) && chip_select_timing_cfg) |-> (chip_select_n != CS_OFF))
    else $error("chip select not with address strobe");
  master_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    (r_reg.st == ST_HOLD && !hold_ack_direction) |-> hold_ack_n_oe && !hold_ack_n_out && !bus_pins_oe)
    else $error("master hold not acknowledged");
endmodule

// ---- bench/ebu_mem_model.sv ----
`timescale 1ns/10ps
// Memory and slow peripheral on the far side of the bus
module ebu_mem_model (
  input wire logic clk,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [4:0] chip_select_n,
  input wire logic [15:0] data_port_out,
  input wire logic [15:0] data_port_oe,
  input wire logic [3:0] rdy_dly,
  input wire logic rdy_pol,
  output logic [15:0] data_port_in,
  output logic ready_in
);
  logic [15:0] mem_reg [5] = '{default: 16'h0000};
  logic [15:0] last_reg = 16'h0000;
  logic [3:0] cnt_reg = 4'h0;
  int slot;
  // One word per select, so a wrong select shows as wrong data
  always_comb begin
    slot = 0;
    for (int j = 4; j >= 0; j--) begin
      if (!chip_select_n[j]) begin
        slot = j;
      end
    end
  end
  // Released bus shows the inverse of the last word, never a stale copy
  assign data_port_in = rd_n ? ~last_reg : mem_reg[slot];
  // Ready held inactive for rdy_dly strobe cycles
  assign ready_in = (cnt_reg >= rdy_dly) ? rdy_pol : ~rdy_pol;
  // Strobe length count and storage of written words
  always @(posedge clk) begin
    cnt_reg <= (rd_n && wr_n) ? 4'h0 : cnt_reg + 4'h1;
    if (!rd_n) last_reg <= mem_reg[slot];
    if (!wr_n) mem_reg[slot] <= data_port_out & data_port_oe;
  end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import ebu_pkg::*;
  logic clk = 0, rst_b = 0, clk_en = 1, single_chip = 0, chip_select_timing_cfg = 0;
  logic arbitration_enable = 0, hold_ack_direction = 0, req_valid = 0, req_write = 0;
  logic hold_request_n = 1, hold_ack_n_in = 1, rdy_pol = 0;
  logic [1:0] addr_space = SPACE_16M;
  logic [15:0] default_bus_config = 16'h0000;
  logic [NUM_WIN-1:0][15:0] window_bus_config = '0;
  logic [NUM_WIN-1:0][15:0] window_address_select = '0;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_ready, resp_valid, resp_err, address_port_oe, ale, rd_n, wr_n, bus_pins_oe;
  logic hold_ack_n_out, hold_ack_n_oe, bus_request_n, ready_in;
  logic [15:0] resp_rdata, data_port_in, data_port_out, data_port_oe, address_port;
  logic [7:0] upper_address, upper_address_oe;
  logic [4:0] chip_select_n;
  logic [3:0] rdy_dly = 4'h0;
  logic [7:0] lanes [4] = '{UPPER_64K, UPPER_256K, UPPER_1M, UPPER_16M};
  int failures = 0, num_checks = 0, cyc = 0, g_n;
  logic [4:0] g_cs;
  logic [15:0] g_mx, g_ad, g_oe;
  logic [7:0] g_up;
  logic g_cst, g_first;

  ebu_ctrl ebu_ctrl_inst (.*);
  ebu_mem_model ebu_mem_model_inst (.*);

  always #10 clk = ~clk;

  // Hang guard, far above the roughly 130 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One CPU request; records selects, address phase and cycle length
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
    int k;
    k = 0;
    g_cs = 5'h1f;
    g_n = 0;
    g_first = 1;
    g_oe = 16'h0000;
    @(posedge clk);
    #1;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    #1;
    req_valid = 0;
    g_n = 1;
    while (resp_valid !== 1'b1 && g_n < 200) begin
      g_cs &= chip_select_n;
      if (ale === 1'b1 && g_first) begin
        g_first = 0;
        g_cst = &chip_select_n;
        g_mx = data_port_out;
        g_ad = address_port;
        g_up = upper_address & upper_address_oe;
      end
      if (wr_n === 1'b0) g_oe = data_port_oe;
      @(posedge clk);
      #1;
      g_n++;
    end
    chk(resp_valid, 1, "no response");
  endtask

  initial begin
    idle(5);
    rst_b = 1;
    window_address_select[0] = 16'h1000;
    window_bus_config[0] = 16'h0400;
    acc(1, 24'h100010, 16'ha5c3);
    chk(g_cs, 5'h1e, "win one cs");
    chk(g_ad, 16'h0010, "demux addr");
    chk(g_oe, 16'hffff, "word oe");
    chk(g_n, 3, "cycle len");
    chk(g_cst, 1, "cs late");
    acc(0, 24'h100010, 16'h0000);
    chk(resp_rdata, 16'ha5c3, "demux read");
    // Wider multiplexed window two over window one
    window_address_select[1] = 16'h1001;
    window_bus_config[1] = 16'h0480;
    acc(1, 24'h100010, 16'h1234);
    chk(g_cs, 5'h1d, "two over one");
    acc(0, 24'h100010, 16'h0000);
    chk(g_mx, 16'h0010, "mux addr");
    chk(resp_rdata, 16'h1234, "mux read");
    // Byte-wide window four over window three
    window_address_select[2] = 16'h2000;
    window_address_select[3] = 16'h2000;
    window_bus_config[2] = 16'h0400;
    window_bus_config[3] = 16'h0500;
    acc(1, 24'h200002, 16'hbeef);
    chk(g_cs, 5'h17, "four over three");
    chk(g_oe, 16'h00ff, "byte oe");
    acc(0, 24'h200002, 16'h0000);
    chk(resp_rdata, 16'h00ef, "byte read");
    // Default region with waits, then long address strobe plus delay
    default_bus_config = 16'h0005;
    acc(0, 24'h300000, 16'h0000);
    chk(g_cs, 5'h0f, "default cs");
    chk(g_n, 8, "wait len");
    default_bus_config = 16'h0060;
    acc(0, 24'h300000, 16'h0000);
    chk(g_n, 5, "ale and delay len");
    default_bus_config = 16'h0000;
    for (int s = 0; s < 4; s++) begin
      addr_space = s[1:0];
      acc(0, 24'h3ab000, 16'h0000);
      chk(g_up, 8'h3a & lanes[s], "upper lanes");
    end
    chip_select_timing_cfg = 1;
    acc(0, 24'h300000, 16'h0000);
    chk(g_cst, 0, "cs early");
    chip_select_timing_cfg = 0;
    // Ready of both polarities, held off by the far side
    rdy_dly = 4'h4;
    for (int p = 0; p < 2; p++) begin
      rdy_pol = p[0];
      window_bus_config[0] = {4'h0, p[0], 11'h600};
      window_bus_config[1] = 16'h0000;
      // Synchronised ready lags the pin; a stale active level would end the cycle early
      idle(5);
      acc(0, 24'h100000, 16'h0000);
      chk(g_n > 8, 1, "ready wait");
      chk(g_n < 20, 1, "ready end");
    end
    single_chip = 1;
    acc(0, 24'h100000, 16'h0000);
    chk(resp_err, 1, "single err");
    chk(bus_pins_oe, 0, "single pins");
    single_chip = 0;
    // Master arbitration: a hold request frees the bus
    arbitration_enable = 1;
    idle(1);
    chk(hold_ack_n_oe, 1, "master ack oe");
    hold_request_n = 0;
    idle(6);
    chk(hold_ack_n_out, 0, "ack given");
    chk(bus_pins_oe, 0, "pins freed");
    hold_request_n = 1;
    idle(6);
    chk(hold_ack_n_out, 1, "ack back");
    chk(bus_pins_oe, 1, "pins back");
    // Slave arbitration: wait for the grant
    hold_ack_direction = 1;
    idle(6);
    chk(hold_ack_n_oe, 0, "slave ack in");
    req_valid = 1;
    idle(2);
    chk(req_ready, 0, "no grant");
    chk(bus_request_n, 0, "bus request");
    hold_ack_n_in = 0;
    acc(0, 24'h300000, 16'h0000);
    chk(g_cs, 5'h0f, "granted access");
    finish_test();
  end
endmodule
